// ### design/cnm_pkg.sv
// Package for the channel tuner: widths, reset values, selector codes and counts.
// Assumes a single 250 MHz clock domain; shared by the tuner and the bench.
package cnm_pkg;
	localparam int CNM_FREQ_W = 32; // Tuning word width
	localparam int CNM_PHASE_W = 20; // Accumulated phase width
	localparam int CNM_POFF_W = 16; // Phase offset width
	localparam int CNM_LUT_W = 18; // Phase bits used for sine and cosine
	localparam int CNM_AMP_W = 17; // Sine and cosine amplitude width
	localparam int CNM_IN_W = 14; // Input sample width
	localparam int CNM_OUT_W = 24; // Mixer product width kept
	localparam int CNM_HOLD_W = 16; // Hold-off counter width
	localparam int CNM_FIFO_DEPTH = 8; // Sample FIFO depth
	localparam int CNM_DITH_PH_BITS = 4; // Phase dither bits
	localparam int CNM_DITH_AMP_BITS = 2; // Amplitude dither bits
	localparam logic [31:0] CNM_FREQ_RST = 32'h0000_0000; // Tuning word after reset
	localparam logic [15:0] CNM_HOLD_RST = 16'h0001; // Hold-off after reset
	localparam logic [15:0] CNM_POFF_RST = 16'h0000; // Phase offset after reset
	localparam logic [22:0] CNM_LFSR_SEED = 23'h00_0001; // Dither generator seed
	localparam logic [3:0] CNM_SEL_CONV = 4'h2; // Selector: converter input
	localparam logic [3:0] CNM_SEL_PRN = 4'h4; // Selector: pseudo-random source
	localparam int CNM_PIPE_LAT = 3; // Sample to product latency in cycles
endpackage

// ### design/cnm_fifo.sv
// Small synchronous FIFO with valid/ready on both sides and registered read data.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module cnm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	output logic [WIDTH-1:0] rd_data_o,
	output logic rd_valid_o,
	input wire logic rd_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH]; // Storage
	logic [AW:0] wptr_ff; // Write pointer with wrap bit
	logic [AW:0] rptr_ff; // Read pointer with wrap bit
	logic full_w; // Honest full
	logic empty_w; // Memory holds nothing beyond output register
	logic pop_w; // Move a word into the output register
	logic push_w; // Accept a word

	assign full_w = (wptr_ff[AW] != rptr_ff[AW]) && (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
	assign empty_w = (wptr_ff == rptr_ff);
	assign push_w = wr_valid_i && !full_w;
	assign pop_w = !empty_w && (!rd_valid_o || rd_ready_i);
	assign wr_ready_o = !full_w;

	// Write side
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wptr_ff <= '0;
		end else if (push_w) begin
			mem_ff[wptr_ff[AW-1:0]] <= wr_data_i;
			wptr_ff <= wptr_ff + 1'b1;
		end
	end

	// Read side; data leaves from a register so the drain sees no memory path
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rptr_ff <= '0;
			rd_valid_o <= 1'b0;
			rd_data_o <= '0;
		end else if (pop_w) begin
			rd_data_o <= mem_ff[rptr_ff[AW-1:0]];
			rd_valid_o <= 1'b1;
			rptr_ff <= rptr_ff + 1'b1;
		end else if (rd_ready_i) begin
			rd_valid_o <= 1'b0;
		end
	end

	chk_fifo_no_overrun: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		full_w |-> !push_w) else $error("fifo written while full");
endmodule

// ### design/cnm_tuner.sv
// Per-channel tuner: oscillator, real mixer and output FIFO in one clock domain.
// Assumes the register port gives write strobes on this clock and the crossbar
// delivers samples with a valid flag on this clock; sync and sleep-exit are pulses.
`timescale 1ns/1ns
module cnm_tuner
	import cnm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [cnm_pkg::CNM_FREQ_W-1:0] carrier_tuning_word_i,
	input wire logic freq_wr_i,
	input wire logic [cnm_pkg::CNM_HOLD_W-1:0] holdoff_i,
	input wire logic holdoff_wr_i,
	input wire logic [cnm_pkg::CNM_POFF_W-1:0] phase_offset_i,
	input wire logic phase_offset_wr_i,
	input wire logic bypass_i,
	input wire logic clear_acc_i,
	input wire logic phase_dither_i,
	input wire logic amp_dither_i,
	input wire logic hop_sync_i,
	input wire logic sleep_exit_i,
	input wire logic [3:0] src_sel_i,
	input wire logic [cnm_pkg::CNM_IN_W-1:0] conv_data_i,
	input wire logic [cnm_pkg::CNM_IN_W-1:0] prn_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [cnm_pkg::CNM_FREQ_W-1:0] active_word_o,
	output logic [cnm_pkg::CNM_HOLD_W-1:0] holdoff_count_o,
	output logic [2*cnm_pkg::CNM_OUT_W-1:0] iq_data_o,
	output logic iq_valid_o,
	input wire logic iq_ready_i
);
	import cnm_pkg::*;

	localparam int PW = CNM_PHASE_W;
	localparam int AW = CNM_AMP_W;
	localparam int OW = CNM_OUT_W;

	// Registers seen by software
	logic [CNM_FREQ_W-1:0] tuning_frequency_word_ff; // Shadow tuning word
	logic [CNM_FREQ_W-1:0] active_word_ff; // Word driving the accumulator
	logic [CNM_HOLD_W-1:0] frequency_holdoff_count_ff; // Programmed hold-off
	logic [CNM_POFF_W-1:0] phase_offset_word_ff; // Programmed phase offset
	logic [CNM_HOLD_W-1:0] hold_cnt_ff; // Running hold-off down-counter
	logic hold_run_ff; // Counter armed
	logic [CNM_FREQ_W-1:0] acc_ff; // Phase accumulator
	logic [22:0] lfsr_ff; // Dither source
	logic load_now_w; // Transfer shadow to active this cycle
	logic [CNM_FREQ_W-1:0] nxt_acc; // Next accumulator value
	// Input acceptance is counted against the FIFO room. The pipeline never
	// stalls, so latency is the same in every mode and no sample is dropped.
	logic take_w; // Sample accepted at this edge
	logic drain_w; // Pair leaves through the drain port at this edge
	logic [3:0] occ_ff; // Pairs in flight or stored, up to the FIFO depth
	logic [3:0] nxt_occ; // Occupancy after this edge
	// Full-width products; a 24-bit product would overflow before scaling
	logic signed [CNM_IN_W+AW-1:0] prod_i_w; // Sample times cosine
	logic signed [CNM_IN_W+AW-1:0] prod_q_w; // Sample times sine
	logic [PW-1:0] phase_w; // Accumulated phase word
	logic [PW-1:0] phase_off_w; // Phase after offset
	logic [CNM_LUT_W-1:0] lut_phase_w; // Phase bits for lookup
	logic signed [AW-1:0] cos_w; // Cosine amplitude
	logic signed [AW-1:0] sin_w; // Sine amplitude
	logic signed [AW-1:0] cos_ff; // Registered cosine
	logic signed [AW-1:0] sin_ff; // Registered sine
	logic signed [CNM_IN_W-1:0] samp_w; // Selected sample
	logic signed [CNM_IN_W-1:0] samp_ff; // Registered sample
	logic v1_ff; // Stage 1 valid
	logic signed [OW-1:0] i_ff; // In-phase product
	logic signed [OW-1:0] q_ff; // Quadrature product
	logic v2_ff; // Stage 2 valid
	logic fifo_ready_w; // FIFO can take a pair

	// Handshakes seen by both sides at the same edge
	assign take_w = in_valid_i && in_ready_o;
	assign drain_w = iq_valid_o && iq_ready_i;

	// Occupancy: counts a pair from acceptance until it is drained
	always_comb begin
		nxt_occ = occ_ff;
		if (take_w && !drain_w) begin
			nxt_occ = occ_ff + 4'h1;
		end else if (drain_w && !take_w) begin
			// One pair out, none in
			nxt_occ = occ_ff - 4'h1;
		end
	end

	// Occupancy register; the registered ready is derived from its next value
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			occ_ff <= '0;
		end else begin
			occ_ff <= nxt_occ;
		end
	end

	// Software writes; tuning word only touches the shadow copy
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tuning_frequency_word_ff <= CNM_FREQ_RST;
			frequency_holdoff_count_ff <= CNM_HOLD_RST;
			phase_offset_word_ff <= CNM_POFF_RST;
		end else begin
			if (freq_wr_i) begin
				tuning_frequency_word_ff <= carrier_tuning_word_i;
			end
			if (holdoff_wr_i) begin
				frequency_holdoff_count_ff <= holdoff_i;
			end
			if (phase_offset_wr_i) begin
				phase_offset_word_ff <= phase_offset_i;
			end
		end
	end

	// A hold-off of one transfers on the sync edge itself; zero also means now
	assign load_now_w = ((hop_sync_i || sleep_exit_i) && frequency_holdoff_count_ff <= 16'h0001)
		|| (hold_run_ff && hold_cnt_ff == 16'h0002);

	// Hold-off down-counter, loaded on a sync, transfers as it steps from two to one
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			hold_cnt_ff <= '0;
			hold_run_ff <= 1'b0;
		end else if (hop_sync_i || sleep_exit_i) begin
			hold_cnt_ff <= frequency_holdoff_count_ff;
			hold_run_ff <= (frequency_holdoff_count_ff > 16'h0001);
		end else if (hold_run_ff) begin
			hold_cnt_ff <= hold_cnt_ff - 16'h0001;
			hold_run_ff <= (hold_cnt_ff > 16'h0002);
		end
	end

	// Active tuning word changes only at the hold-off transfer, on the sync edge or counted out
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			active_word_ff <= CNM_FREQ_RST;
		end else if (load_now_w) begin
			active_word_ff <= tuning_frequency_word_ff;
		end
	end

	// Pseudo-random generator for both dither kinds
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			lfsr_ff <= CNM_LFSR_SEED;
		end else begin
			lfsr_ff <= {lfsr_ff[21:0], lfsr_ff[22] ^ lfsr_ff[17]};
		end
	end

	// Accumulator next value: wraps modulo 2^32, so the word acts as a signed turn fraction
	always_comb begin
		nxt_acc = acc_ff + active_word_ff;
		if (phase_dither_i) begin
			nxt_acc = nxt_acc + {{(CNM_FREQ_W-CNM_DITH_PH_BITS){1'b0}},
				lfsr_ff[CNM_DITH_PH_BITS-1:0]};
		end
	end

	// Phase accumulator; runs each clock, cleared on the transfer when asked
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			acc_ff <= '0;
		end else if (load_now_w && clear_acc_i) begin
			acc_ff <= '0;
		end else begin
			acc_ff <= nxt_acc;
		end
	end

	// Offset is added after the accumulator, so clearing never disturbs it
	assign phase_w = acc_ff[CNM_FREQ_W-1 -: PW];
	assign phase_off_w = phase_w + {phase_offset_word_ff, {(PW-CNM_POFF_W){1'b0}}};
	assign lut_phase_w = phase_off_w[PW-1 -: CNM_LUT_W];

	// Sine and cosine from the top phase bits; half-wave parabola approximation
	// trades spur level for area, no table memory is needed
	function automatic logic signed [AW-1:0] cnm_sine(input logic [CNM_LUT_W-1:0] ph);
		logic [CNM_LUT_W-2:0] x;
		logic [CNM_LUT_W-2:0] xm;
		logic [2*(CNM_LUT_W-1)-1:0] prod;
		logic [AW-2:0] mag;
		// Position inside the half turn; the top bit picks the sign
		x = ph[CNM_LUT_W-2:0];
		xm = ~x;
		prod = x * xm;
		mag = prod[2*(CNM_LUT_W-1)-3 -: (AW-1)];
		// Peak is clipped so that amplitude dither can never wrap the sign
		if (mag > 16'hfffc) begin
			mag = 16'hfffc;
		end
		cnm_sine = ph[CNM_LUT_W-1] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
	endfunction

	// Cosine leads sine by a quarter turn
	always_comb begin
		sin_w = cnm_sine(lut_phase_w);
		cos_w = cnm_sine(lut_phase_w + 18'h1_0000);
	end

	// Stage 1: register oscillator and selected sample
	always_comb begin
		case (src_sel_i)
			CNM_SEL_PRN: samp_w = prn_data_i;
			default: samp_w = conv_data_i;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cos_ff <= '0;
			sin_ff <= '0;
			samp_ff <= '0;
			v1_ff <= 1'b0;
		end else begin
			cos_ff <= amp_dither_i ? cos_w + $signed({15'h0000, lfsr_ff[21:20]}) : cos_w;
			sin_ff <= amp_dither_i ? sin_w + $signed({15'h0000, lfsr_ff[19:18]}) : sin_w;
			samp_ff <= samp_w;
			v1_ff <= take_w;
		end
	end

	// The two multipliers, kept at full width
	assign prod_i_w = samp_ff * cos_ff;
	assign prod_q_w = samp_ff * sin_ff;

	// Stage 2: two multipliers, or a plain pass on bypass with the same latency
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			i_ff <= '0;
			q_ff <= '0;
			v2_ff <= 1'b0;
		end else begin
			v2_ff <= v1_ff;
			if (bypass_i) begin
				i_ff <= {samp_ff, {(OW-CNM_IN_W){1'b0}}};
				q_ff <= '0;
			end else begin
				// Scaling drops the amplitude fraction bits
				i_ff <= OW'(prod_i_w >>> (AW-1));
				q_ff <= OW'(-(prod_q_w >>> (AW-1)));
			end
		end
	end

	// Output FIFO; its ready is only checked, the occupancy count gates the input
	cnm_fifo #(
		.WIDTH(2*OW),
		.DEPTH(CNM_FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.wr_data_i({i_ff, q_ff}),
		.wr_valid_i(v2_ff),
		.wr_ready_o(fifo_ready_w),
		.rd_data_o(iq_data_o),
		.rd_valid_o(iq_valid_o),
		.rd_ready_i(iq_ready_i)
	);

	// Status outputs from flip-flops
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			in_ready_o <= 1'b0;
			active_word_o <= '0;
			holdoff_count_o <= '0;
		end else begin
			// Ready only while a further pair is sure to find room
			in_ready_o <= (nxt_occ < 4'(CNM_FIFO_DEPTH));
			active_word_o <= active_word_ff;
			holdoff_count_o <= hold_cnt_ff;
		end
	end

	chk_shadow_holds_active: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(freq_wr_i && !load_now_w) |=> $stable(active_word_ff))
		else $error("tuning write reached active word early");
	chk_holdoff_one_now: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(hop_sync_i && frequency_holdoff_count_ff == 16'h0001)
		|=> active_word_ff == $past(tuning_frequency_word_ff))
		else $error("hold-off one did not update at once");
	chk_holdoff_three_delay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(hop_sync_i && frequency_holdoff_count_ff == 16'h0003 && !freq_wr_i)
		##1 (!hop_sync_i && !sleep_exit_i && !freq_wr_i)[*2]
		|=> active_word_ff == $past(tuning_frequency_word_ff, 3))
		else $error("hold-off count not honoured");
	chk_acc_step_word: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!load_now_w && !phase_dither_i) |=> acc_ff == $past(acc_ff) + $past(active_word_ff))
		else $error("accumulator did not step by tuning word");
	chk_clear_on_hop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(load_now_w && clear_acc_i) |=> acc_ff == 32'h0000_0000)
		else $error("accumulator not cleared on hop");
	chk_continuous_hop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(load_now_w && !clear_acc_i && !phase_dither_i)
		|=> acc_ff == $past(acc_ff) + $past(active_word_ff))
		else $error("hop broke phase continuity");
	chk_offset_added: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		phase_off_w == PW'(acc_ff[31:12] + {phase_offset_word_ff, 4'h0}))
		else $error("phase offset not applied");
	chk_bypass_pass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		bypass_i |=> (i_ff[OW-1 -: CNM_IN_W] == $past(samp_ff) && q_ff == '0))
		else $error("bypass altered the sample");
	chk_pipe_latency: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		take_w |-> ##4 iq_valid_o)
		else $error("sample lost in pipeline");
	chk_mix_product: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!bypass_i |=> i_ff == OW'(($signed({{AW{$past(samp_ff[CNM_IN_W-1])}}, $past(samp_ff)})
		* $past(cos_ff)) >>> (AW-1)))
		else $error("in-phase product wrong");
	chk_fifo_room: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		v2_ff |-> fifo_ready_w)
		else $error("pair offered to a full fifo");
endmodule

// ### sim/cnm_far_model.sv
// Far-side model: the channel input crossbar source and the decimator sink.
// Assumes the tuner's valid/ready handshakes on clk_i; the bench fills tx_q and sets stall.
`timescale 1ns/1ns
module cnm_far_model (
	input wire logic clk_i,
	output logic [13:0] conv_data_o,
	output logic [13:0] prn_data_o,
	output logic in_valid_o,
	input wire logic in_ready_i,
	input wire logic [47:0] iq_data_i,
	input wire logic iq_valid_i,
	output logic iq_ready_o
);
	logic [27:0] tx_q[$]; // Pending {converter, pseudo-random} pairs
	logic [47:0] rx_q[$]; // Products taken by the sink
	time acc_t; // Edge where the first sample went in
	time rx_t; // Edge where the first product came out
	logic first = 1'b1; // Arms the input time stamp
	logic stall = 1'b0; // Sink refuses while set
	logic acc; // Sample handshake seen at this edge
	logic got; // Product handshake seen at this edge
	initial begin
		conv_data_o = 14'h0;
		prn_data_o = 14'h0;
		in_valid_o = 1'b0;
		iq_ready_o = 1'b1;
	end
	// Sample both handshakes on the edge, move just after it like real logic would
	always @(posedge clk_i) begin
		acc = in_valid_o && in_ready_i;
		got = iq_valid_i && iq_ready_o;
		if (acc && first) begin
			acc_t = $time;
		end
		if (got && rx_q.size() == 0) begin
			rx_t = $time;
		end
		if (got) begin
			rx_q.push_back(iq_data_i);
		end
		#1;
		if (acc) begin
			first = 1'b0;
			tx_q.delete(0);
		end
		// Both sources are offered; the tuner's selector picks one
		if (tx_q.size() != 0) begin
			in_valid_o = 1'b1;
			{conv_data_o, prn_data_o} = tx_q[0];
		end else begin
			// Idle lines toggle so stale data never passes for a sample
			in_valid_o = 1'b0;
			conv_data_o = ~conv_data_o;
			prn_data_o = ~prn_data_o;
		end
		iq_ready_o = !stall;
	end
endmodule

// ### sim/channel_nco_mixer_bench.sv
// Self-checking bench for the channel tuner: tuning word table, then streams and resets.
// Assumes cnm_tuner and cnm_far_model; inputs move 1 ns after the rising edge.
`timescale 1ns/1ns
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin errors++; $display("FAIL %0t %s", $time, m); end end
module channel_nco_mixer_bench;
	import cnm_pkg::*;
	typedef struct { logic [31:0] word; logic [15:0] hold; logic slp; } cnm_row_t;
	logic clk_i, rst_n_i, freq_wr_i, holdoff_wr_i, phase_offset_wr_i, bypass_i, clear_acc_i;
	logic phase_dither_i, amp_dither_i, hop_sync_i, sleep_exit_i, in_valid_i, in_ready_o;
	logic iq_valid_o, iq_ready_i;
	logic [31:0] carrier_tuning_word_i, active_word_o, prev;
	logic [15:0] holdoff_i, phase_offset_i, holdoff_count_o;
	logic [3:0] src_sel_i;
	logic [13:0] conv_data_i, prn_data_i;
	logic [47:0] iq_data_o;
	int errors = 0;
	int total_checks = 0;
	int cyc = 0;
	// Boundary words of the signed fraction, with short, zero and long hold-offs
	cnm_row_t rows[5] = '{'{32'h8000_0000, 16'h0001, 1'b0}, '{32'h7fff_ffff, 16'h0000, 1'b0},
		'{32'h4000_0000, 16'h0003, 1'b0}, '{32'he000_0000, 16'h0005, 1'b1},
		'{32'h0000_0000, 16'h0002, 1'b0}};
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	cnm_tuner u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .carrier_tuning_word_i(carrier_tuning_word_i),
		.freq_wr_i(freq_wr_i), .holdoff_i(holdoff_i), .holdoff_wr_i(holdoff_wr_i),
		.phase_offset_i(phase_offset_i), .phase_offset_wr_i(phase_offset_wr_i),
		.bypass_i(bypass_i), .clear_acc_i(clear_acc_i), .phase_dither_i(phase_dither_i),
		.amp_dither_i(amp_dither_i), .hop_sync_i(hop_sync_i), .sleep_exit_i(sleep_exit_i),
		.src_sel_i(src_sel_i), .conv_data_i(conv_data_i), .prn_data_i(prn_data_i),
		.in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .active_word_o(active_word_o),
		.holdoff_count_o(holdoff_count_o), .iq_data_o(iq_data_o), .iq_valid_o(iq_valid_o),
		.iq_ready_i(iq_ready_i));
	cnm_far_model u_far (.clk_i(clk_i), .conv_data_o(conv_data_i), .prn_data_o(prn_data_i),
		.in_valid_o(in_valid_i), .in_ready_i(in_ready_o), .iq_data_i(iq_data_o),
		.iq_valid_i(iq_valid_o), .iq_ready_o(iq_ready_i));
	// Lands 1 ns after the n-th rising edge from now
	task automatic tick(int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// One-cycle strobe on a control input
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask
	// Shadow write, hold-off write, sync, then watch the exact transfer cycle
	task automatic hop(logic [31:0] w, logic [15:0] h, logic slp, logic [31:0] old);
		int hh;
		hh = (h == 16'h0) ? 1 : int'(h);
		carrier_tuning_word_i = w;
		pulse(freq_wr_i);
		holdoff_i = h;
		pulse(holdoff_wr_i);
		`CHK(active_word_o, old, "shadow word leaked")
		if (slp) pulse(sleep_exit_i);
		else pulse(hop_sync_i);
		if (hh > 1) tick(hh - 1);
		`CHK(active_word_o, old, "word moved early")
		tick(1);
		`CHK(active_word_o, w, "word not moved")
	endtask
	// Sends n samples, optionally stalls the sink, checks count, latency and bypass data
	task automatic stream(int n, logic [3:0] sel, logic byp, int stall_n);
		logic [13:0] s;
		src_sel_i = sel;
		bypass_i = byp;
		u_far.rx_q.delete();
		u_far.first = 1'b1;
		u_far.stall = (stall_n > 0);
		for (int i = 0; i < n; i++) u_far.tx_q.push_back({14'h0123 + 14'(i * 37), 14'h2f00 - 14'(i * 5)});
		tick(stall_n);
		if (stall_n > 0) `CHK(in_ready_o, 1'b0, "no back-pressure when full")
		u_far.stall = 1'b0;
		for (int k = 0; k < 300 && u_far.rx_q.size() < n; k++) tick(1);
		`CHK(u_far.rx_q.size(), n, "sample count")
		for (int i = 0; byp && i < u_far.rx_q.size(); i++) begin
			s = (sel == CNM_SEL_PRN) ? 14'h2f00 - 14'(i * 5) : 14'h0123 + 14'(i * 37);
			`CHK(u_far.rx_q[i], {s, 10'h0, 24'h0}, "bypass data")
		end
		if (stall_n == 0 && n > 0) `CHK((u_far.rx_t - u_far.acc_t) / 4, CNM_PIPE_LAT + 1, "latency")
		$display("stream of %0d done", n);
	endtask
	// Zero frequency: the product sign follows the phase offset alone
	task automatic mix_sign(logic [15:0] off, logic pos);
		phase_offset_i = off;
		pulse(phase_offset_wr_i);
		stream(1, CNM_SEL_CONV, 1'b0, 0);
		`CHK($signed(u_far.rx_q[0][47:24]) > 0, pos, "in-phase sign")
		if (pos) `CHK(u_far.rx_q[0][23:0], 24'h0, "quadrature at zero phase")
	endtask
	task close_out;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Hang guard: the whole run needs well under a few thousand cycles
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			$display("FAIL %0t timeout", $time);
			close_out;
		end
	end
	initial begin
		{rst_n_i, freq_wr_i, holdoff_wr_i, phase_offset_wr_i, bypass_i, clear_acc_i} = 6'h0;
		{phase_dither_i, amp_dither_i, hop_sync_i, sleep_exit_i} = 4'h0;
		carrier_tuning_word_i = 32'h0;
		holdoff_i = 16'h0;
		phase_offset_i = 16'h0;
		src_sel_i = CNM_SEL_CONV;
		tick(10);
		rst_n_i = 1'b1;
		`CHK(active_word_o, 32'h0, "reset word")
		`CHK({iq_valid_o, holdoff_count_o}, 17'h0, "reset outputs")
		$display("reset test done");
		prev = 32'h0;
		foreach (rows[r]) begin
			hop(rows[r].word, rows[r].hold, rows[r].slp, prev);
			prev = rows[r].word;
		end
		$display("tuning table done");
		clear_acc_i = 1'b1;
		hop(32'h0, 16'h0001, 1'b0, 32'h0);
		tick(4);
		mix_sign(16'h0000, 1'b1);
		mix_sign(16'h8000, 1'b0);
		stream(6, CNM_SEL_CONV, 1'b1, 0);
		stream(6, CNM_SEL_PRN, 1'b1, 0);
		stream(16, CNM_SEL_PRN, 1'b1, 40);
		phase_dither_i = 1'b1;
		amp_dither_i = 1'b1;
		stream(5, CNM_SEL_CONV, 1'b0, 0);
		// Reset in mid-run with a full FIFO and a non-zero active word
		hop(32'h1234_5678, 16'h0001, 1'b0, 32'h0);
		u_far.stall = 1'b1;
		stream(0, CNM_SEL_CONV, 1'b1, 0);
		u_far.stall = 1'b1;
		for (int i = 0; i < 12; i++) u_far.tx_q.push_back(28'h0);
		tick(20);
		rst_n_i = 1'b0;
		u_far.tx_q.delete();
		tick(2);
		rst_n_i = 1'b1;
		u_far.stall = 1'b0;
		`CHK({iq_valid_o, active_word_o}, 33'h0, "mid-run reset")
		$display("mid-run reset done");
		close_out;
	end
endmodule
